// file: hw/pfp_port.sv
`timescale 1ns/1ps
// Function
// R1 - receive flag low while a readable byte waits, high otherwise
// R2 - host reads only when receive flag low, by pulsing strobe low
// R3 - transmit flag low while transmit FIFO can take a byte
// R4 - host writes only when transmit flag low, strobe high then low
// R5 - drive data lines while read strobe low, release when high
// R6 - read strobe falling edge fetches next receive byte
// R7 - write strobe falling edge appends data lines to transmit FIFO
// R8 - receive flag held high at least 80 ns after each read
// R9 - transmit flag held high at least 80 ns after each write
// R10 - strobes synchronised and edge-detected before flags or pointers
module pfp_port
   import pfp_pkg::*;
(
   input wire logic mclk_i, // system clock, 100 MHz
   input wire logic nrst_i, // async reset, active low
   input wire logic rd_n_i, // host read strobe, active low
   input wire logic wr_i, // host write strobe, falling edge writes
   input wire logic [DATA_W-1:0] fifo_byte_bus_i, // data lines in
   output logic [DATA_W-1:0] fifo_byte_bus_o, // data lines out
   output logic fifo_byte_bus_oe_n_o, // low while driving
   output logic rx_avail_n_o, // low when a byte can be read
   output logic tx_space_n_o, // low when a byte can be written
   input wire logic rx_push_i, // core pushes a byte for host
   input wire logic [DATA_W-1:0] rx_data_i, // byte to push
   output logic rx_ready_o, // receive FIFO has room
   input wire logic tx_pop_i, // core takes a host byte
   output logic [DATA_W-1:0] tx_data_o, // head of transmit FIFO
   output logic tx_valid_o // transmit FIFO not empty
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      pfp_ptrs_t rx;
      pfp_ptrs_t tx;
      pfp_phase_t rph;
      pfp_phase_t wph;
      logic [HOLD_W-1:0] rhold;
      logic [HOLD_W-1:0] whold;
      pfp_byte_t cur;
      logic oe_n;
      logic rx_n;
      logic tx_n;
      logic rx_rdy;
      logic tx_vld;
      logic [DATA_W-1:0] tx_head;
   } pfp_st_t;

   pfp_st_t st;
   pfp_st_t next_st;
   logic [DATA_W-1:0] rx_mem [FIFO_DEPTH];
   logic [DATA_W-1:0] tx_mem [FIFO_DEPTH];
   logic rd_fall, rd_rise;
   logic wr_lvl, wr_fall;
   logic rx_wr, tx_wr, rx_rd, tx_rd;

   pfp_edge_sync #(
      .IDLE_LVL(1'b1)
   ) u_rd_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(rd_n_i),
      .level_o(),
      .fall_o(rd_fall),
      .rise_o(rd_rise)
   );

   pfp_edge_sync u_wr_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(wr_i),
      .level_o(wr_lvl),
      .fall_o(wr_fall),
      .rise_o()
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      rx_wr = rx_push_i && (st.rx.cnt != CNT_FULL);
      rx_rd = 1'b0;
      tx_wr = 1'b0;
      tx_rd = tx_pop_i && (st.tx.cnt != CNT_ZERO);
      // read side
      case (st.rph)
         PFP_IDLE: begin
            if (rd_fall) begin // R6
               next_st.rph = PFP_ACTIVE;
               next_st.cur.valid = (st.rx.cnt != CNT_ZERO);
               if (st.rx.cnt != CNT_ZERO) begin
                  rx_rd = 1'b1;
                  next_st.cur.data = rx_mem[st.rx.rptr];
               end
            end
         end
         PFP_ACTIVE: begin
            if (rd_rise) begin
               next_st.rph = PFP_HOLD;
               next_st.rhold = HOLD_LOAD; // R8
            end
         end
         PFP_HOLD: begin
            if (st.rhold != HOLD_ZERO) begin
               next_st.rhold = st.rhold - 4'h1;
            end else begin
               next_st.rph = PFP_IDLE;
            end
         end
         default: next_st.rph = PFP_IDLE;
      endcase
      // write side
      case (st.wph)
         PFP_IDLE: begin
            if (wr_fall) begin // R7
               tx_wr = (st.tx.cnt != CNT_FULL);
               next_st.wph = PFP_HOLD;
               next_st.whold = HOLD_LOAD; // R9
            end
         end
         PFP_HOLD: begin
            if (st.whold != HOLD_ZERO) begin
               next_st.whold = st.whold - 4'h1;
            end else if (!wr_lvl) begin
               next_st.wph = PFP_IDLE;
            end
         end
         default: next_st.wph = PFP_IDLE;
      endcase
      // pointers
      if (rx_wr) next_st.rx.wptr = st.rx.wptr + PTR_ONE;
      if (rx_rd) next_st.rx.rptr = st.rx.rptr + PTR_ONE;
      next_st.rx.cnt = st.rx.cnt + CNT_W'(rx_wr) - CNT_W'(rx_rd);
      if (tx_wr) next_st.tx.wptr = st.tx.wptr + PTR_ONE;
      if (tx_rd) next_st.tx.rptr = st.tx.rptr + PTR_ONE;
      next_st.tx.cnt = st.tx.cnt + CNT_W'(tx_wr) - CNT_W'(tx_rd);
      // registered outputs
      next_st.oe_n = ~(next_st.rph == PFP_ACTIVE); // R5
      next_st.rx_n = ~((next_st.rph == PFP_IDLE) && !rd_rise
                       && (next_st.rx.cnt != CNT_ZERO)); // R1
      next_st.tx_n = ~((next_st.wph == PFP_IDLE)
                       && (next_st.tx.cnt != CNT_FULL)); // R3
      next_st.rx_rdy = (next_st.rx.cnt != CNT_FULL);
      next_st.tx_vld = (next_st.tx.cnt != CNT_ZERO);
      // bypass when the new head slot is the one written this cycle
      next_st.tx_head = (tx_wr && (next_st.tx.rptr == st.tx.wptr)) ?
         fifo_byte_bus_i : tx_mem[next_st.tx.rptr];
   end

   // ----------------------------------------------------------------
   // registers and memories
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
         st.oe_n <= 1'b1;
         st.rx_n <= 1'b1;
         st.tx_n <= 1'b1;
         st.rx_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rx_wr) rx_mem[st.rx.wptr] <= rx_data_i;
      if (tx_wr) tx_mem[st.tx.wptr] <= fifo_byte_bus_i; // R7
   end

   assign fifo_byte_bus_o = st.cur.data;
   assign fifo_byte_bus_oe_n_o = st.oe_n;
   assign rx_avail_n_o = st.rx_n;
   assign tx_space_n_o = st.tx_n;
   assign rx_ready_o = st.rx_rdy;
   assign tx_valid_o = st.tx_vld;
   assign tx_data_o = st.tx_head;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   rx_hold_high_a: assert property ( // R8
      @(posedge mclk_i) disable iff (!nrst_i)
      rd_rise ##1 1'b1 |-> rx_avail_n_o [*8])
      else $error("receive flag reasserted too soon");
   tx_hold_high_a: assert property ( // R9
      @(posedge mclk_i) disable iff (!nrst_i)
      wr_fall |=> tx_space_n_o [*8])
      else $error("transmit flag reasserted too soon");
   bus_drive_a: assert property ( // R5
      @(posedge mclk_i) disable iff (!nrst_i)
      rd_fall |=> !fifo_byte_bus_oe_n_o until_with rd_rise)
      else $error("data lines not driven during read");
   bus_release_a: assert property ( // R5
      @(posedge mclk_i) disable iff (!nrst_i)
      rd_rise |=> fifo_byte_bus_oe_n_o)
      else $error("data lines not released");
   rx_empty_flag_a: assert property ( // R1
      @(posedge mclk_i) disable iff (!nrst_i)
      !rx_avail_n_o |-> st.rx.cnt != CNT_ZERO)
      else $error("receive flag low with empty FIFO");
   tx_full_flag_a: assert property ( // R3
      @(posedge mclk_i) disable iff (!nrst_i)
      !tx_space_n_o |-> st.tx.cnt != CNT_FULL)
      else $error("transmit flag low with full FIFO");
   rd_pop_a: assert property ( // R6
      @(posedge mclk_i) disable iff (!nrst_i)
      (rd_fall && st.rph == PFP_IDLE && st.rx.cnt != CNT_ZERO
       && !rx_push_i) |=> st.rx.cnt == $past(st.rx.cnt) - 5'h01)
      else $error("read edge did not pop");
   wr_push_a: assert property ( // R7
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_fall && st.wph == PFP_IDLE && st.tx.cnt != CNT_FULL
       && !tx_pop_i) |=> st.tx.cnt == $past(st.tx.cnt) + 5'h01)
      else $error("write edge did not push");
   rd_busy_flag_a: assert property ( // R8
      @(posedge mclk_i) disable iff (!nrst_i)
      st.rph != PFP_IDLE |-> rx_avail_n_o)
      else $error("receive flag low during a read");
   wr_busy_flag_a: assert property ( // R9
      @(posedge mclk_i) disable iff (!nrst_i)
      st.wph != PFP_IDLE |-> tx_space_n_o)
      else $error("transmit flag low during a write");
   drive_in_read_a: assert property ( // R5
      @(posedge mclk_i) disable iff (!nrst_i)
      !fifo_byte_bus_oe_n_o |-> st.rph == PFP_ACTIVE)
      else $error("data lines driven outside a read");
   read_byte_held_a: assert property ( // R5
      @(posedge mclk_i) disable iff (!nrst_i)
      st.rph == PFP_ACTIVE |=> $stable(fifo_byte_bus_o))
      else $error("read byte changed during strobe");
   tx_head_a: assert property ( // R7
      @(posedge mclk_i) disable iff (!nrst_i)
      tx_valid_o |-> tx_data_o == tx_mem[st.tx.rptr])
      else $error("transmit head does not match FIFO");
endmodule

// file: hw/pfp_pkg.sv
package pfp_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FLAG_HOLD_NS = 80;
   localparam int FLAG_HOLD_CYC =
      (FLAG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W = 4;
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(FLAG_HOLD_CYC);
   localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // strobe phase of each side
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PFP_IDLE = 2'b00,
      PFP_ACTIVE = 2'b01,
      PFP_HOLD = 2'b11
   } pfp_phase_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic valid;
   } pfp_byte_t;

   typedef struct packed {
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [CNT_W-1:0] cnt;
   } pfp_ptrs_t;
endpackage

// file: hw/pfp_edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with falling and rising edge pulses
module pfp_edge_sync
   import pfp_pkg::*;
#(
   parameter logic IDLE_LVL = 1'b0 // pin level while no strobe runs
)
(
   input wire logic mclk_i, // system clock
   input wire logic nrst_i, // async reset, active low
   input wire logic pin_i, // asynchronous pin level
   output logic level_o, // synchronised level
   output logic fall_o, // one-cycle high-to-low pulse
   output logic rise_o // one-cycle low-to-high pulse
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic fall;
      logic rise;
   } pfp_sync_st_t;

   pfp_sync_st_t st;
   pfp_sync_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.meta = pin_i;
      next_st.sync = st.meta;
      next_st.prev = st.sync;
      next_st.fall = st.prev & ~st.sync; // R10
      next_st.rise = ~st.prev & st.sync; // R10
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // chain starts at the idle level so no false edge follows reset
         st <= '{meta: IDLE_LVL, sync: IDLE_LVL, prev: IDLE_LVL,
                 fall: 1'b0, rise: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign level_o = st.sync;
   assign fall_o = st.fall;
   assign rise_o = st.rise;
endmodule

// file: dv/pfp_host_model.sv
`timescale 1ns/1ps
// host side of the parallel port: strobes and data lines
module pfp_host_model
   import pfp_pkg::*;
(
   input wire logic mclk_i, // system clock
   input wire logic rx_avail_n_i, // device holds a byte
   input wire logic tx_space_n_i, // device can take a byte
   input wire logic [DATA_W-1:0] bus_i, // resolved data lines
   output logic rd_n_o, // read strobe, active low
   output logic wr_o, // write strobe
   output logic [DATA_W-1:0] bus_o, // host data
   output logic bus_oe_n_o // low while host drives
);
   initial begin
      rd_n_o = 1'b1;
      wr_o = 1'b0;
      bus_o = 8'h00;
      bus_oe_n_o = 1'b1;
   end
   // counts edges until the chosen flag shows val, at most lim
   task automatic wait_lvl(input bit sel, input bit val, input int lim,
                           output int n);
      n = 0;
      while (n < lim && (sel ? tx_space_n_i : rx_avail_n_i) !== val) begin
         @(posedge mclk_i);
         n++;
      end
   endtask
   task automatic rd_byte(output logic [DATA_W-1:0] d, output int gap);
      int n;
      wait_lvl(1'b0, 1'b0, 100, n);
      @(posedge mclk_i);
      rd_n_o <= 1'b0;
      repeat (7) @(posedge mclk_i);
      d = bus_i;
      rd_n_o <= 1'b1;
      wait_lvl(1'b0, 1'b0, 60, gap);
   endtask
   // data stays on the lines until the flag settles again
   task automatic wr_byte(input logic [DATA_W-1:0] d, output int gap);
      int n;
      wait_lvl(1'b1, 1'b0, 100, n);
      @(posedge mclk_i);
      wr_o <= 1'b1;
      bus_o <= d;
      bus_oe_n_o <= 1'b0;
      repeat (5) @(posedge mclk_i);
      wr_o <= 1'b0;
      wait_lvl(1'b1, 1'b1, 10, n);
      wait_lvl(1'b1, 1'b0, 60, gap);
      bus_oe_n_o <= 1'b1;
   endtask
endmodule

// file: dv/test_parallel_fifo_host_port.sv
`timescale 1ns/1ps
module test_parallel_fifo_host_port;
   import pfp_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic rd_n, wr, dut_oe_n, host_oe_n, rx_avail_n, tx_space_n;
   logic rx_push = 1'b0;
   logic tx_pop = 1'b0;
   logic rx_ready, tx_valid;
   logic [7:0] rx_data = 8'h00;
   logic [7:0] bus, last_d, dut_d, host_d, tx_data;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   int error_cnt = 0;
   int checks_done = 0;
   always #5 mclk = ~mclk;
   initial last_d = 8'h00;
   // undriven lines show a pattern that changes every cycle
   assign bus = !dut_oe_n ? dut_d : (!host_oe_n ? host_d : ~last_d);
   always @(posedge mclk) last_d <= bus;
   pfp_port i_dut (.mclk_i(mclk), .nrst_i(nrst), .rd_n_i(rd_n), .wr_i(wr),
      .fifo_byte_bus_i(bus), .fifo_byte_bus_o(dut_d),
      .fifo_byte_bus_oe_n_o(dut_oe_n), .rx_avail_n_o(rx_avail_n),
      .tx_space_n_o(tx_space_n), .rx_push_i(rx_push), .rx_data_i(rx_data),
      .rx_ready_o(rx_ready), .tx_pop_i(tx_pop), .tx_data_o(tx_data),
      .tx_valid_o(tx_valid));
   pfp_host_model i_host (.mclk_i(mclk), .rx_avail_n_i(rx_avail_n),
      .tx_space_n_i(tx_space_n), .bus_i(bus), .rd_n_o(rd_n), .wr_o(wr),
      .bus_o(host_d), .bus_oe_n_o(host_oe_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
   // ----------------------------------------------------------------
   // receive side: fill past full, then read all back
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] b, d;
      int gap;
      void'($urandom(96));
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(rx_avail_n, 1'b1);
      chk(tx_space_n, 1'b0);
      chk(dut_oe_n, 1'b1);
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         b = 8'($urandom);
         @(posedge mclk);
         rx_push <= 1'b1;
         rx_data <= b;
         if (i < FIFO_DEPTH) rxq.push_back(b);
      end
      @(posedge mclk);
      rx_push <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk(rx_ready, 1'b0);
      chk(rx_avail_n, 1'b0);
      while (rxq.size() > 0) begin
         i_host.rd_byte(d, gap);
         chk(d, rxq.pop_front());
         chk(dut_oe_n, 1'b1);
         if (rxq.size() > 0) chk(32'(gap >= 8), 32'h1);
      end
      chk(rx_avail_n, 1'b1);
      // ----------------------------------------------------------------
      // transmit side: write until full, then drain through the core
      // ----------------------------------------------------------------
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         b = 8'($urandom);
         txq.push_back(b);
         i_host.wr_byte(b, gap);
         if (i < FIFO_DEPTH - 1) chk(32'(gap >= 8), 32'h1);
      end
      chk(tx_space_n, 1'b1);
      while (txq.size() > 0) begin
         chk(tx_data, txq.pop_front());
         @(posedge mclk);
         tx_pop <= 1'b1;
         @(posedge mclk);
         tx_pop <= 1'b0;
         @(negedge mclk);
      end
      chk(tx_valid, 1'b0);
      repeat (12) @(posedge mclk);
      chk(tx_space_n, 1'b0);
      close_out();
   end
endmodule
